// [rtl/drp_pkg.sv]
/*
  constants shared by both ends of the attribute reconfiguration port.
  assumes nothing of its surroundings.
*/
package drp_pkg;
  localparam int unsigned DRP_ADDR_W     = 9;
  localparam int unsigned DRP_DATA_W     = 16;
  localparam int unsigned DRP_CELLS      = 512;
  localparam int unsigned DRP_LAT_W      = 4;
  // cycles of the link clock spent on a cell access before commit
  localparam int unsigned DRP_ACCESS_LAT = 2;
  localparam logic [DRP_DATA_W-1:0] DRP_CELL_RESET = 16'h0000;
  localparam logic [DRP_LAT_W-1:0]  DRP_CNT_ZERO   = 4'h0;
  localparam logic [DRP_LAT_W-1:0]  DRP_CNT_ONE    = 4'h1;
endpackage : drp_pkg

// [rtl/drp_if.sv]
/*
  link between requester and attribute port.
  assumes the bench drives drp_clk and connects both modports.
*/
`timescale 1ns/1ps
interface drp_if
  import drp_pkg::*;
(
  input wire logic drp_clk
);
  logic                  en;
  logic                  we;
  logic [DRP_ADDR_W-1:0] addr;
  logic [DRP_DATA_W-1:0] reconfig_write_data;
  logic                  rdy;
  logic [DRP_DATA_W-1:0] read_data;

  modport device (
    input  drp_clk,
    input  en,
    input  we,
    input  addr,
    input  reconfig_write_data,
    output rdy,
    output read_data
  );

  modport requester (
    input  drp_clk,
    output en,
    output we,
    output addr,
    output reconfig_write_data,
    input  rdy,
    input  read_data
  );
endinterface : drp_if

// [rtl/drp_device_end.sv]
/*
  attribute cell port: 512 cells of 16 bits reached over the link, clocked
  by the link clock; every written cell is handed to the core clock domain
  by a toggle handshake before ready is given.
  assumes srst_i and ce_i belong to ref_clk_i; both are resynchronised
  into the link domain. the link clock must run while operations are open.
*/
`timescale 1ns/1ps
module drp_device_end
  import drp_pkg::*;
#(
  parameter int unsigned ACCESS_LAT = DRP_ACCESS_LAT
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  ce_i,
  drp_if.device                      drp,
  output logic                       cfg_update_o,
  output logic [DRP_ADDR_W-1:0]      cfg_update_addr_o,
  output logic [DRP_DATA_W-1:0]      cfg_update_data_o
);

  // ************************************************************
  // types and constants
  // ************************************************************
  typedef enum logic [1:0] {
    DRP_ST_IDLE,
    DRP_ST_BUSY,
    DRP_ST_COMMIT,
    DRP_ST_DONE
  } drp_dev_state_t;

  localparam logic [DRP_LAT_W-1:0] LAT_CNT = ACCESS_LAT[DRP_LAT_W-1:0];

  // ************************************************************
  // link domain: reset and enable resynchronisers
  // ************************************************************
  logic                  link_rst_meta_reg;
  logic                  link_rst_reg;
  logic                  link_ce_meta_reg;
  logic                  link_ce_reg;

  always_ff @(posedge drp.drp_clk) begin
    link_rst_meta_reg <= srst_i;
    link_rst_reg      <= link_rst_meta_reg;
    link_ce_meta_reg  <= ce_i;
    link_ce_reg       <= link_ce_meta_reg;
  end

  // ************************************************************
  // link domain: operation sequencing
  // ************************************************************
  drp_dev_state_t        state_reg;
  logic                  port_free;
  logic                  accept;
  logic                  access_end;
  logic [DRP_LAT_W-1:0]  cnt_reg;
  logic                  op_we_reg;
  logic [DRP_ADDR_W-1:0] op_addr_reg;
  logic [DRP_DATA_W-1:0] op_wdata_reg;
  logic [DRP_DATA_W-1:0] rdata_reg;
  logic [DRP_DATA_W-1:0] cells [DRP_CELLS];
  logic                  commit_req_reg;
  logic                  ack_meta_reg;
  logic                  ack_sync_reg;
  logic                  commit_seen;

  // ready cycle counts as free so a back-to-back enable is taken
  assign port_free   = (state_reg == DRP_ST_IDLE) || (state_reg == DRP_ST_DONE);
  // inputs other than enable are looked at only through accept
  assign accept      = link_ce_reg && drp.en && port_free;
  assign access_end  = (state_reg == DRP_ST_BUSY) && (cnt_reg == DRP_CNT_ZERO);
  assign commit_seen = (ack_sync_reg == commit_req_reg);

  always_ff @(posedge drp.drp_clk) begin
    if (link_rst_reg) begin
      state_reg <= DRP_ST_IDLE;
    end else if (link_ce_reg) begin
      unique case (state_reg)
        DRP_ST_IDLE: begin
          if (accept) begin
            state_reg <= DRP_ST_BUSY;
          end
        end
        DRP_ST_BUSY: begin
          if (access_end) begin
            state_reg <= op_we_reg ? DRP_ST_COMMIT : DRP_ST_DONE;
          end
        end
        DRP_ST_COMMIT: begin
          if (commit_seen) begin
            state_reg <= DRP_ST_DONE;
          end
        end
        DRP_ST_DONE: begin
          // ready lasts one cycle whatever follows
          state_reg <= accept ? DRP_ST_BUSY : DRP_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge drp.drp_clk) begin
    if (link_rst_reg) begin
      op_we_reg    <= 1'b0;
      op_addr_reg  <= '0;
      op_wdata_reg <= DRP_CELL_RESET;
    end else if (accept) begin
      op_we_reg    <= drp.we;
      op_addr_reg  <= drp.addr;
      op_wdata_reg <= drp.reconfig_write_data;
    end
  end

  always_ff @(posedge drp.drp_clk) begin
    if (link_rst_reg) begin
      cnt_reg <= DRP_CNT_ZERO;
    end else if (accept) begin
      // at least one busy cycle even for a zero latency setting
      cnt_reg <= (LAT_CNT == DRP_CNT_ZERO) ? DRP_CNT_ZERO : LAT_CNT - DRP_CNT_ONE;
    end else if (link_ce_reg && (state_reg == DRP_ST_BUSY) && (cnt_reg != DRP_CNT_ZERO)) begin
      cnt_reg <= cnt_reg - DRP_CNT_ONE;
    end
  end

  // ************************************************************
  // link domain: cell store
  // ************************************************************
  always_ff @(posedge drp.drp_clk) begin
    if (link_rst_reg) begin
      for (int i = 0; i < DRP_CELLS; i++) begin
        cells[i] <= DRP_CELL_RESET;
      end
    end else if (link_ce_reg && access_end && op_we_reg) begin
      cells[op_addr_reg] <= op_wdata_reg;
    end
  end

  // read data is only loaded by a read; it is meaningful in the ready cycle only
  always_ff @(posedge drp.drp_clk) begin
    if (link_rst_reg) begin
      rdata_reg <= DRP_CELL_RESET;
    end else if (link_ce_reg && access_end && !op_we_reg) begin
      rdata_reg <= cells[op_addr_reg];
    end
  end

  assign drp.rdy       = (state_reg == DRP_ST_DONE);
  assign drp.read_data = rdata_reg;

  // ************************************************************
  // link domain: commit handshake towards the core
  // ************************************************************
  // op_addr_reg and op_wdata_reg stay still until ready, so the core side
  // may sample them once it sees the toggle
  always_ff @(posedge drp.drp_clk) begin
    if (link_rst_reg) begin
      commit_req_reg <= 1'b0;
    end else if (link_ce_reg && access_end && op_we_reg) begin
      commit_req_reg <= ~commit_req_reg;
    end
  end

  logic                  upd_ack_reg;

  always_ff @(posedge drp.drp_clk) begin
    if (link_rst_reg) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else if (link_ce_reg) begin
      ack_meta_reg <= upd_ack_reg;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  // ************************************************************
  // core domain: update delivery
  // ************************************************************
  logic                  req_meta_reg;
  logic                  req_sync_reg;
  logic                  upd_pulse_reg;
  logic [DRP_ADDR_W-1:0] upd_addr_reg;
  logic [DRP_DATA_W-1:0] upd_data_reg;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
    end else if (ce_i) begin
      req_meta_reg <= commit_req_reg;
      req_sync_reg <= req_meta_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      upd_ack_reg   <= 1'b0;
      upd_pulse_reg <= 1'b0;
      upd_addr_reg  <= '0;
      upd_data_reg  <= DRP_CELL_RESET;
    end else if (ce_i) begin
      upd_pulse_reg <= 1'b0;
      if (req_sync_reg != upd_ack_reg) begin
        upd_ack_reg   <= req_sync_reg;
        upd_pulse_reg <= 1'b1;
        upd_addr_reg  <= op_addr_reg;
        upd_data_reg  <= op_wdata_reg;
      end
    end
  end

  assign cfg_update_o      = upd_pulse_reg;
  assign cfg_update_addr_o = upd_addr_reg;
  assign cfg_update_data_o = upd_data_reg;

endmodule // drp_device_end

// [rtl/drp_requester_end.sv]
/*
  requester end: takes one command at a time on ref_clk_i, issues it on the
  link in the link clock domain and returns the answer on ref_clk_i.
  assumes the link clock runs while a command is open; srst_i and ce_i
  belong to ref_clk_i and are resynchronised into the link domain.
*/
`timescale 1ns/1ps
module drp_requester_end
  import drp_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  ce_i,
  input  wire logic                  cmd_valid_i,
  output logic                       cmd_ready_o,
  input  wire logic                  cmd_write_i,
  input  wire logic [DRP_ADDR_W-1:0] cmd_addr_i,
  input  wire logic [DRP_DATA_W-1:0] cmd_wdata_i,
  output logic                       rsp_valid_o,
  output logic [DRP_DATA_W-1:0]      rsp_rdata_o,
  drp_if.requester                   drp
);

  // ************************************************************
  // core domain: command capture
  // ************************************************************
  typedef enum logic {DRP_LK_IDLE, DRP_LK_WAIT} drp_link_state_t;

  logic                  busy_reg;
  logic                  cmd_req_reg;
  logic                  cmd_we_reg;
  logic [DRP_ADDR_W-1:0] cmd_addr_reg;
  logic [DRP_DATA_W-1:0] cmd_wdata_reg;
  logic                  rsp_ack_reg;
  logic                  ack_meta_reg;
  logic                  ack_sync_reg;
  logic                  rsp_pulse_reg;
  logic [DRP_DATA_W-1:0] rsp_rdata_reg;
  logic [DRP_DATA_W-1:0] link_rdata_reg;

  // a single command in flight keeps one operation outstanding on the link
  assign cmd_ready_o = !busy_reg;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else if (ce_i) begin
      ack_meta_reg <= rsp_ack_reg;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      busy_reg      <= 1'b0;
      cmd_req_reg   <= 1'b0;
      cmd_we_reg    <= 1'b0;
      cmd_addr_reg  <= '0;
      cmd_wdata_reg <= DRP_CELL_RESET;
    end else if (ce_i) begin
      if (!busy_reg && cmd_valid_i) begin
        busy_reg      <= 1'b1;
        cmd_req_reg   <= ~cmd_req_reg;
        cmd_we_reg    <= cmd_write_i;
        cmd_addr_reg  <= cmd_addr_i;
        cmd_wdata_reg <= cmd_wdata_i;
      end else if (busy_reg && (ack_sync_reg == cmd_req_reg)) begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rsp_pulse_reg <= 1'b0;
      rsp_rdata_reg <= DRP_CELL_RESET;
    end else if (ce_i) begin
      rsp_pulse_reg <= busy_reg && (ack_sync_reg == cmd_req_reg);
      if (busy_reg && (ack_sync_reg == cmd_req_reg)) begin
        rsp_rdata_reg <= link_rdata_reg;
      end
    end
  end

  assign rsp_valid_o = rsp_pulse_reg;
  assign rsp_rdata_o = rsp_rdata_reg;

  // ************************************************************
  // link domain: port signalling
  // ************************************************************
  logic                  link_rst_meta_reg;
  logic                  link_rst_reg;
  logic                  link_ce_meta_reg;
  logic                  link_ce_reg;
  logic                  req_meta_reg;
  logic                  req_sync_reg;
  drp_link_state_t       lk_state_reg;
  logic                  en_reg;
  logic                  we_reg;
  logic [DRP_ADDR_W-1:0] addr_reg;
  logic [DRP_DATA_W-1:0] wdata_reg;

  always_ff @(posedge drp.drp_clk) begin
    link_rst_meta_reg <= srst_i;
    link_rst_reg      <= link_rst_meta_reg;
    link_ce_meta_reg  <= ce_i;
    link_ce_reg       <= link_ce_meta_reg;
  end

  always_ff @(posedge drp.drp_clk) begin
    if (link_rst_reg) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
    end else if (link_ce_reg) begin
      req_meta_reg <= cmd_req_reg;
      req_sync_reg <= req_meta_reg;
    end
  end

  // enable is a one-cycle pulse with address and data beside it
  always_ff @(posedge drp.drp_clk) begin
    if (link_rst_reg) begin
      lk_state_reg   <= DRP_LK_IDLE;
      en_reg         <= 1'b0;
      we_reg         <= 1'b0;
      addr_reg       <= '0;
      wdata_reg      <= DRP_CELL_RESET;
      rsp_ack_reg    <= 1'b0;
      link_rdata_reg <= DRP_CELL_RESET;
    end else if (link_ce_reg) begin
      en_reg <= 1'b0;
      unique case (lk_state_reg)
        DRP_LK_IDLE: begin
          if (req_sync_reg != rsp_ack_reg) begin
            en_reg       <= 1'b1;
            we_reg       <= cmd_we_reg;
            addr_reg     <= cmd_addr_reg;
            wdata_reg    <= cmd_wdata_reg;
            lk_state_reg <= DRP_LK_WAIT;
          end
        end
        DRP_LK_WAIT: begin
          if (drp.rdy && !en_reg) begin
            link_rdata_reg <= drp.read_data;
            rsp_ack_reg    <= req_sync_reg;
            lk_state_reg   <= DRP_LK_IDLE;
          end
        end
      endcase
    end
  end

  assign drp.en                  = en_reg;
  assign drp.we                  = we_reg;
  assign drp.addr                = addr_reg;
  assign drp.reconfig_write_data = wdata_reg;

endmodule // drp_requester_end

// [verification/drp_chk.sv]
/*
  checker for the link between requester end and device end.
  assumes it sees the drp_if signals and srst_i; ce held high during ops.
*/
`timescale 1ns/1ps
module drp_chk
  import drp_pkg::*;
#(
  parameter int unsigned ACCESS_LAT = DRP_ACCESS_LAT
) (
  input wire logic                  drp_clk,
  input wire logic                  srst_i,
  input wire logic                  en,
  input wire logic                  we,
  input wire logic [DRP_ADDR_W-1:0] addr,
  input wire logic [DRP_DATA_W-1:0] reconfig_write_data,
  input wire logic                  rdy,
  input wire logic [DRP_DATA_W-1:0] read_data
);
  // ****************
  // open operation shadow
  // ****************
  logic                  pend_reg;
  logic                  rd_reg;
  logic [DRP_ADDR_W-1:0] addr_reg;
  logic [7:0]            cnt_reg;
  logic [DRP_DATA_W-1:0] mem_reg [DRP_CELLS];
  logic                  take;

  // a zero latency setting still spends one busy cycle in the device
  localparam int unsigned EFF_LAT = (ACCESS_LAT == 0) ? 1 : ACCESS_LAT;

  // an op may start in the ready cycle of the previous one
  assign take = en && (!pend_reg || rdy);

  default clocking cb @(posedge drp_clk); endclocking
  default disable iff (srst_i);

  always_ff @(posedge drp_clk) begin
    if (srst_i) begin
      pend_reg <= 1'b0;
    end else if (take) begin
      pend_reg <= 1'b1;
      rd_reg   <= !we;
      addr_reg <= addr;
    end else if (rdy) begin
      pend_reg <= 1'b0;
    end
  end

  // saturates so a stuck op cannot wrap back into the latency window
  always_ff @(posedge drp_clk) begin
    cnt_reg <= take ? 8'h01 : ((cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01);
  end

  always_ff @(posedge drp_clk) begin
    if (srst_i) begin
      for (int i = 0; i < DRP_CELLS; i++) mem_reg[i] <= DRP_CELL_RESET;
    end else if (take && we) begin
      mem_reg[addr] <= reconfig_write_data;
    end
  end

  // ****************
  // properties
  // ****************
  a_rdy_single: assert property (rdy |=> !rdy)
    else $error("ready held for more than one cycle");
  a_rdy_idle: assert property (!pend_reg |-> !rdy)
    else $error("ready without an open operation");
  a_read_early: assert property (pend_reg && rd_reg && cnt_reg <= EFF_LAT |-> !rdy)
    else $error("read ready too early");
  a_read_lat: assert property (pend_reg && rd_reg && cnt_reg == EFF_LAT + 1 |-> rdy)
    else $error("read ready missing at its latency");
  a_read_value: assert property (rdy && pend_reg && rd_reg |-> read_data == mem_reg[addr_reg])
    else $error("read data differs from cell content");
  a_write_bound: assert property (take && we |=> !rdy ##1 !rdy ##[1:40] rdy)
    else $error("write ready outside its window");
  a_one_open: assert property (pend_reg && !rdy |-> !en)
    else $error("enable raised while an op is open");
  a_en_single: assert property (en |=> !en)
    else $error("enable held for more than one cycle");
  a_rdata_hold: assert property ($changed(read_data) |-> rdy && pend_reg && rd_reg)
    else $error("read data moved outside a read ready cycle");

  c_read: cover property (rdy && pend_reg && rd_reg);
  c_write: cover property (rdy && pend_reg && !rd_reg);
  c_wr_rd: cover property (rdy && !rd_reg ##[1:100] take && !we);
endmodule // drp_chk

// [verification/tb_dynamic_reconfig_port.sv]
/*
  testbench joining requester end and device end over drp_if.
  assumes the design files are compiled first; makes both clocks itself.
*/
`timescale 1ns/1ps
module tb_dynamic_reconfig_port;
  import drp_pkg::*;

  typedef struct packed {
    logic                  w;
    logic [DRP_ADDR_W-1:0] a;
    logic [DRP_DATA_W-1:0] d;
    logic [DRP_DATA_W-1:0] q;
  } drp_row_t;

  localparam drp_row_t ROWS [9] = '{
    '{1'b1, 9'h000, 16'h1234, 16'h0000}, '{1'b1, 9'h1FF, 16'hA5C3, 16'h0000},
    '{1'b0, 9'h000, 16'h0000, 16'h1234}, '{1'b0, 9'h1FF, 16'h0000, 16'hA5C3},
    '{1'b0, 9'h0AA, 16'h0000, 16'h0000}, '{1'b1, 9'h0AA, 16'hFFFF, 16'h0000},
    '{1'b0, 9'h0AA, 16'h0000, 16'hFFFF}, '{1'b1, 9'h001, 16'h0001, 16'h0000},
    '{1'b0, 9'h000, 16'h0000, 16'h1234}};

  logic                  ref_clk_i;
  logic                  drp_clk;
  logic                  srst_i;
  logic                  ce_i;
  logic                  cmd_valid_i;
  logic                  cmd_ready_o;
  logic                  cmd_write_i;
  logic [DRP_ADDR_W-1:0] cmd_addr_i;
  logic [DRP_DATA_W-1:0] cmd_wdata_i;
  logic                  rsp_valid_o;
  logic [DRP_DATA_W-1:0] rsp_rdata_o;
  logic                  cfg_update_o;
  logic [DRP_ADDR_W-1:0] cfg_update_addr_o;
  logic [DRP_DATA_W-1:0] cfg_update_data_o;
  logic [DRP_DATA_W-1:0] q;
  int                    err_count;
  int                    num_checks;
  int                    upd_cnt;
  int                    en_cnt;
  int                    rdy_cnt;
  int                    n;

  drp_if drp_if_i (.drp_clk(drp_clk));

  drp_requester_end drp_requester_end_i (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
    .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .drp(drp_if_i));

  drp_device_end #(.ACCESS_LAT(DRP_ACCESS_LAT)) drp_device_end_i (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i), .drp(drp_if_i), .cfg_update_o(cfg_update_o),
    .cfg_update_addr_o(cfg_update_addr_o), .cfg_update_data_o(cfg_update_data_o));

  drp_chk #(.ACCESS_LAT(DRP_ACCESS_LAT)) drp_chk_i (
    .drp_clk(drp_clk), .srst_i(srst_i), .en(drp_if_i.en), .we(drp_if_i.we), .addr(drp_if_i.addr),
    .reconfig_write_data(drp_if_i.reconfig_write_data), .rdy(drp_if_i.rdy), .read_data(drp_if_i.read_data));

  // ****************
  // clocks and monitors
  // ****************
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    drp_clk = 1'b0;
    #3;
    forever #6 drp_clk = ~drp_clk;
  end

  always @(posedge ref_clk_i) if (cfg_update_o === 1'b1) upd_cnt++;
  always @(posedge drp_clk) if (drp_if_i.en === 1'b1) en_cnt++;
  always @(posedge drp_clk) if (drp_if_i.rdy === 1'b1) rdy_cnt++;

  // ****************
  // tasks
  // ****************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // entered just after a rising edge; returns just after the response edge
  task automatic run_cmd(input logic w, input logic [8:0] a, input logic [15:0] d, output logic [15:0] r);
    int   k;
    logic taken;
    k = 0;
    cmd_valid_i = 1'b1;
    cmd_write_i = w;
    cmd_addr_i  = a;
    cmd_wdata_i = d;
    // ready is read while settled before the taking edge, never in its time step
    do begin
      taken = (cmd_ready_o === 1'b1) && (ce_i === 1'b1);
      @(posedge ref_clk_i);
      #1;
      k++;
    end while (!taken && k < 100);
    cmd_valid_i = 1'b0;
    k = 0;
    while (rsp_valid_o !== 1'b1 && k < 200) begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end
    check("response arrived", k < 200, 1);
    r = rsp_rdata_o;
  endtask

  initial begin
    #(3000 * 50);
    err_count++;
    report_and_stop();
  end

  // ****************
  // sequence
  // ****************
  initial begin
    err_count = 0; num_checks = 0; upd_cnt = 0; en_cnt = 0; rdy_cnt = 0;
    srst_i = 1'b1;
    ce_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_write_i = 1'b0;
    cmd_addr_i = 9'h000;
    cmd_wdata_i = 16'h0000;
    repeat (2) @(posedge ref_clk_i);
    #1;
    check("en in reset", drp_if_i.en, 0);
    check("rdy in reset", drp_if_i.rdy, 0);
    check("cmd ready in reset", cmd_ready_o, 1);
    @(posedge ref_clk_i);
    #1;
    srst_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    for (int i = 0; i < 9; i++) begin
      n = upd_cnt;
      run_cmd(ROWS[i].w, ROWS[i].a, ROWS[i].d, q);
      if (ROWS[i].w) begin
        repeat (4) @(posedge ref_clk_i);
        #1;
        check("update count", upd_cnt, n + 1);
        check("update addr", cfg_update_addr_o, ROWS[i].a);
        check("update data", cfg_update_data_o, ROWS[i].d);
      end else begin
        check("read data", q, ROWS[i].q);
      end
    end
    check("ready per enable", rdy_cnt, en_cnt);
    // clock enable low: a pending command must not reach the link
    ce_i = 1'b0;
    n = en_cnt;
    cmd_valid_i = 1'b1;
    cmd_addr_i = 9'h1FF;
    repeat (10) @(posedge ref_clk_i);
    #1;
    check("frozen link", en_cnt, n);
    ce_i = 1'b1;
    run_cmd(1'b0, 9'h1FF, 16'h0000, q);
    check("read after freeze", q, 16'hA5C3);
    // reset in mid write, then cell 1FF reads back at its reset value
    cmd_valid_i = 1'b1;
    cmd_write_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    cmd_valid_i = 1'b0;
    srst_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    srst_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    check("no response after reset", rsp_valid_o, 0);
    run_cmd(1'b0, 9'h1FF, 16'h0000, q);
    check("cell after reset", q, 16'h0000);
    report_and_stop();
  end
endmodule // tb_dynamic_reconfig_port
